// [hdl/tpw_params.svh]
// Constants for the three-generator PWM module: map, fields, counts.
// Summary of operation
// - Down mode: period down to zero, reload.
// - Up/down mode: zero to period and back.
// - Direction low in down mode, follows counting.
// - One-cycle zero and period pulses.
// - Match pulses, direction-qualified in up/down mode.
// - Match above period never fires.
// - Four events down mode, six up/down.
// - Matches ignored when coinciding zero/period.
// - Coinciding matches: A to first, B second.
// - Per event action: keep, toggle, low, high.
// - Dead-band off passes; on delays rising edge.
// - Second output inverted input, delayed after fall.
// - Selected events raise generator interrupt.
// - Interrupts use undelayed counter events.
// - Global sync reset clears chosen counters.
// - Immediate update takes effect at zero.
// - Synced update waits for global update, zero.
// - Update mode separate for period and matches.
// - Fault forces enabled outputs inactive, interrupts.
// - Stall: keep counting or stop at zero.
// - One mask selects outputs reaching pins.
// - Optional final per-output inversion.
`ifndef TPW_PARAMS_SVH
`define TPW_PARAMS_SVH
`define TPW_NUM_GEN   3
`define TPW_NUM_PIN   6
`define TPW_NUM_EV    6
`define TPW_ACT_W     2
`define TPW_ACTS_W    12
`define TPW_CTL_W     5
`define TPW_GEN_MSB   7
`define TPW_GEN_LSB   6
`define TPW_REG_MSB   5
`define TPW_OFS_UPDATE 8'h00
`define TPW_OFS_SYNC   8'h04
`define TPW_OFS_PASS   8'h08
`define TPW_OFS_POL    8'h0C
`define TPW_OFS_FORCE  8'h10
`define TPW_OFS_STATUS 8'h20
`define TPW_G_CTL     6'h00
`define TPW_G_SEL     6'h04
`define TPW_G_FLAGS   6'h08
`define TPW_G_CLR     6'h0C
`define TPW_G_PERIOD  6'h10
`define TPW_G_COUNT   6'h14
`define TPW_G_MA      6'h18
`define TPW_G_MB      6'h1C
`define TPW_G_ACTA    6'h20
`define TPW_G_ACTB    6'h24
`define TPW_G_DBCTL   6'h28
`define TPW_G_RISE    6'h2C
`define TPW_G_FALL    6'h30
`define TPW_CTL_RUN    0
`define TPW_CTL_UPDOWN 1
`define TPW_CTL_PSYNC  2
`define TPW_CTL_MSYNC  3
`define TPW_CTL_STALL  4
`define TPW_EV_ZERO   0
`define TPW_EV_LOAD   1
`define TPW_EV_AUP    2
`define TPW_EV_ADN    3
`define TPW_EV_BUP    4
`define TPW_EV_BDN    5
`define TPW_EV_A_BITS 6'h0C
`define TPW_EV_B_BITS 6'h30
`define TPW_CNT_ZERO  16'h0000
`define TPW_CNT_ONE   16'h0001
`define TPW_CNT_MAX   16'hFFFF
`endif

// [hdl/tpw_pkg.sv]
// Types shared by the three-generator PWM module.
package tpw_pkg;
  typedef logic [15:0] tpw_cnt_t;
  typedef logic [31:0] tpw_data_t;
  typedef enum logic [1:0] {
    TPW_ACT_KEEP,
    TPW_ACT_TOGGLE,
    TPW_ACT_LOW,
    TPW_ACT_HIGH
  } tpw_act_e;
endpackage : tpw_pkg

// [hdl/tpw_top.sv]
// Three-generator PWM module with dead-band, update and output control.
`timescale 1ns/1ps
`default_nettype none
`include "tpw_params.svh"
module tpw_top
  import tpw_pkg::*;
(
  input  wire logic       clk,          // 25 MHz clock
  input  wire logic       rst,          // Asynchronous reset, high
  input  wire logic [7:0] bus_addr,     // Register byte address
  input  wire logic [31:0] bus_wdata,   // Register write data
  input  wire logic       bus_we,       // Write strobe
  input  wire logic       bus_re,       // Read strobe
  output logic      [31:0] bus_rdata,   // Read data, cycle after strobe
  input  wire logic       fault_pin,    // External fault, high active
  input  wire logic       debug_stall,  // Debugger stall request
  output logic      [5:0] pwm_pin,      // Conditioned outputs to pins
  output logic      [2:0] gen_irq,      // Per-generator event pulses
  output logic            fault_irq     // Fault level interrupt
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  function automatic logic gen_hit(input logic [7:0] a, input int g);
    return a[`TPW_GEN_MSB:`TPW_GEN_LSB] == 2'(g + 1);
  endfunction : gen_hit

  // Later events in the list win, but masking leaves at most one class.
  function automatic logic wave_step(input logic cur,
                                     input logic [11:0] acts,
                                     input logic [5:0] ev);
    logic v;
    v = cur;
    for (int e = 0; e < `TPW_NUM_EV; e++)
    begin
      if (ev[e])
      begin
        case (tpw_act_e'(acts[e*`TPW_ACT_W +: `TPW_ACT_W]))
          TPW_ACT_TOGGLE: v = ~v;
          TPW_ACT_LOW:    v = 1'b0;
          TPW_ACT_HIGH:   v = 1'b1;
          default:        v = v;
        endcase
      end
    end
    return v;
  endfunction : wave_step

  logic           fault_meta_reg;
  logic           fault_s_reg;
  logic           stall_meta_reg;
  logic           stall_s_reg;
  logic     [5:0] pass_mask_reg;
  logic     [5:0] pol_mask_reg;
  logic     [5:0] force_mask_reg;
  logic     [5:0] raw_sig;
  logic     [5:0] pin_next;
  logic     [2:0] irq_hit;
  logic     [2:0] sync_hit;
  logic     [2:0] upd_hit;
  logic    [31:0] rdata_next;
  logic     [1:0] rd_gen;
  tpw_cnt_t       count_reg   [`TPW_NUM_GEN];
  tpw_cnt_t       per_sh_reg  [`TPW_NUM_GEN];
  tpw_cnt_t       ma_sh_reg   [`TPW_NUM_GEN];
  tpw_cnt_t       mb_sh_reg   [`TPW_NUM_GEN];
  tpw_cnt_t       rise_reg    [`TPW_NUM_GEN];
  tpw_cnt_t       fall_reg    [`TPW_NUM_GEN];
  logic     [4:0] ctl_reg     [`TPW_NUM_GEN];
  logic     [5:0] sel_reg     [`TPW_NUM_GEN];
  logic     [5:0] flags_reg   [`TPW_NUM_GEN];
  logic    [11:0] acta_reg    [`TPW_NUM_GEN];
  logic    [11:0] actb_reg    [`TPW_NUM_GEN];
  logic           db_en_reg   [`TPW_NUM_GEN];

  // Pins cross into the clock domain through two flops each.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fault_meta_reg <= 1'b0;
      fault_s_reg    <= 1'b0;
      stall_meta_reg <= 1'b0;
      stall_s_reg    <= 1'b0;
    end
    else
    begin
      fault_meta_reg <= fault_pin;
      fault_s_reg    <= fault_meta_reg;
      stall_meta_reg <= debug_stall;
      stall_s_reg    <= stall_meta_reg;
    end
  end

  assign sync_hit = (bus_we && bus_addr == `TPW_OFS_SYNC) ?
                    bus_wdata[2:0] : 3'h0;
  assign upd_hit  = (bus_we && bus_addr == `TPW_OFS_UPDATE) ?
                    bus_wdata[2:0] : 3'h0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pass_mask_reg  <= 6'h00;
      pol_mask_reg   <= 6'h00;
      force_mask_reg <= 6'h00;
    end
    else if (bus_we)
    begin
      if (bus_addr == `TPW_OFS_PASS)
        pass_mask_reg <= bus_wdata[5:0];
      if (bus_addr == `TPW_OFS_POL)
        pol_mask_reg <= bus_wdata[5:0];
      if (bus_addr == `TPW_OFS_FORCE)
        force_mask_reg <= bus_wdata[5:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < `TPW_NUM_GEN; g++)
    begin : gen_blk
      logic     wr;
      logic     tick;
      logic     zero_ev;
      logic     load_ev;
      logic     ma;
      logic     mb;
      logic     ab;
      logic     load_p;
      logic     load_m;
      logic     dir_reg;
      logic     arm_p_reg;
      logic     arm_m_reg;
      logic     wave_a_reg;
      logic     wave_b_reg;
      logic     db_a_reg;
      logic     db_b_reg;
      logic [5:0] ev_raw;
      logic [5:0] ev;
      logic [5:0] ev_a;
      logic [5:0] ev_b;
      tpw_cnt_t per_act_reg;
      tpw_cnt_t ma_act_reg;
      tpw_cnt_t mb_act_reg;
      tpw_cnt_t per_eff;
      tpw_cnt_t cnt_r_reg;
      tpw_cnt_t cnt_f_reg;

      assign wr = bus_we && gen_hit(bus_addr, g);

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          ctl_reg[g]    <= 5'h00;
          sel_reg[g]    <= 6'h00;
          per_sh_reg[g] <= `TPW_CNT_ZERO;
          ma_sh_reg[g]  <= `TPW_CNT_ZERO;
          mb_sh_reg[g]  <= `TPW_CNT_ZERO;
          acta_reg[g]   <= 12'h000;
          actb_reg[g]   <= 12'h000;
          db_en_reg[g]  <= 1'b0;
          rise_reg[g]   <= `TPW_CNT_ZERO;
          fall_reg[g]   <= `TPW_CNT_ZERO;
        end
        else if (wr)
        begin
          case (bus_addr[`TPW_REG_MSB:0])
            `TPW_G_CTL:    ctl_reg[g]    <= bus_wdata[4:0];
            `TPW_G_SEL:    sel_reg[g]    <= bus_wdata[5:0];
            `TPW_G_PERIOD: per_sh_reg[g] <= bus_wdata[15:0];
            `TPW_G_MA:     ma_sh_reg[g]  <= bus_wdata[15:0];
            `TPW_G_MB:     mb_sh_reg[g]  <= bus_wdata[15:0];
            `TPW_G_ACTA:   acta_reg[g]   <= bus_wdata[11:0];
            `TPW_G_ACTB:   actb_reg[g]   <= bus_wdata[11:0];
            `TPW_G_DBCTL:  db_en_reg[g]  <= bus_wdata[0];
            `TPW_G_RISE:   rise_reg[g]   <= bus_wdata[15:0];
            `TPW_G_FALL:   fall_reg[g]   <= bus_wdata[15:0];
            default:       ;
          endcase
        end
      end

      // A stop-at-zero stall freezes only once the count is zero.
      assign tick = ctl_reg[g][`TPW_CTL_RUN] &&
                    !(stall_s_reg && ctl_reg[g][`TPW_CTL_STALL] &&
                      count_reg[g] == `TPW_CNT_ZERO);
      assign zero_ev = tick && count_reg[g] == `TPW_CNT_ZERO;
      assign load_ev = tick && count_reg[g] == per_act_reg;
      assign ma = tick && count_reg[g] == ma_act_reg &&
                  ma_act_reg <= per_act_reg;
      assign mb = tick && count_reg[g] == mb_act_reg &&
                  mb_act_reg <= per_act_reg;
      // Down mode holds dir low, so up-qualified events never fire there.
      assign ev_raw = {mb && !dir_reg, mb && dir_reg,
                       ma && !dir_reg, ma && dir_reg,
                       load_ev, zero_ev};
      assign ev = (zero_ev || load_ev) ?
                  (ev_raw & ~(`TPW_EV_A_BITS | `TPW_EV_B_BITS)) :
                  ev_raw;
      assign ab = |(ev & `TPW_EV_A_BITS) && |(ev & `TPW_EV_B_BITS);
      assign ev_a = ab ? (ev & ~`TPW_EV_B_BITS) : ev;
      assign ev_b = ab ? (ev & ~`TPW_EV_A_BITS) : ev;

      assign load_p = zero_ev &&
                      (!ctl_reg[g][`TPW_CTL_PSYNC] || arm_p_reg);
      assign load_m = zero_ev &&
                      (!ctl_reg[g][`TPW_CTL_MSYNC] || arm_m_reg);
      assign per_eff = load_p ? per_sh_reg[g] : per_act_reg;

      // Synced values wait for a global update, then for zero.
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          per_act_reg <= `TPW_CNT_ZERO;
          ma_act_reg  <= `TPW_CNT_ZERO;
          mb_act_reg  <= `TPW_CNT_ZERO;
          arm_p_reg   <= 1'b0;
          arm_m_reg   <= 1'b0;
        end
        else
        begin
          if (load_p)
            per_act_reg <= per_sh_reg[g];
          if (load_m)
          begin
            ma_act_reg <= ma_sh_reg[g];
            mb_act_reg <= mb_sh_reg[g];
          end
          if (upd_hit[g])
            arm_p_reg <= 1'b1;
          else if (load_p)
            arm_p_reg <= 1'b0;
          if (upd_hit[g])
            arm_m_reg <= 1'b1;
          else if (load_m)
            arm_m_reg <= 1'b0;
        end
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          count_reg[g] <= `TPW_CNT_ZERO;
          dir_reg      <= 1'b0;
        end
        else if (sync_hit[g])
        begin
          count_reg[g] <= `TPW_CNT_ZERO;
          dir_reg      <= 1'b0;
        end
        else if (tick && !ctl_reg[g][`TPW_CTL_UPDOWN])
        begin
          dir_reg <= 1'b0;
          count_reg[g] <= zero_ev ? per_eff :
                          count_reg[g] - `TPW_CNT_ONE;
        end
        else if (tick && dir_reg)
        begin
          if (count_reg[g] >= per_act_reg)
            dir_reg <= 1'b0;
          if (count_reg[g] >= per_act_reg && !zero_ev)
            count_reg[g] <= count_reg[g] - `TPW_CNT_ONE;
          else if (count_reg[g] < per_act_reg)
            count_reg[g] <= count_reg[g] + `TPW_CNT_ONE;
        end
        else if (tick)
        begin
          if (zero_ev)
          begin
            dir_reg      <= 1'b1;
            count_reg[g] <= (per_eff == `TPW_CNT_ZERO) ?
                            `TPW_CNT_ZERO : `TPW_CNT_ONE;
          end
          else
            count_reg[g] <= count_reg[g] - `TPW_CNT_ONE;
        end
        else if (!ctl_reg[g][`TPW_CTL_UPDOWN])
          dir_reg <= 1'b0;
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          wave_a_reg <= 1'b0;
          wave_b_reg <= 1'b0;
        end
        else
        begin
          wave_a_reg <= wave_step(wave_a_reg, acta_reg[g], ev_a);
          wave_b_reg <= wave_step(wave_b_reg, actb_reg[g], ev_b);
        end
      end

      // With dead-band on, both outputs derive from one input, so they never overlap; off, they pass A and B.
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          cnt_r_reg <= `TPW_CNT_ZERO;
          cnt_f_reg <= `TPW_CNT_ZERO;
          db_a_reg  <= 1'b0;
          db_b_reg  <= 1'b0;
        end
        else
        begin
          cnt_r_reg <= !wave_a_reg ? `TPW_CNT_ZERO :
                       (cnt_r_reg == `TPW_CNT_MAX) ? cnt_r_reg :
                       cnt_r_reg + `TPW_CNT_ONE;
          cnt_f_reg <= wave_a_reg ? `TPW_CNT_ZERO :
                       (cnt_f_reg == `TPW_CNT_MAX) ? cnt_f_reg :
                       cnt_f_reg + `TPW_CNT_ONE;
          if (db_en_reg[g])
          begin
            db_a_reg <= wave_a_reg && cnt_r_reg >= rise_reg[g];
            db_b_reg <= !wave_a_reg && cnt_f_reg >= fall_reg[g];
          end
          else
          begin
            db_a_reg <= wave_a_reg;
            db_b_reg <= wave_b_reg;
          end
        end
      end

      // Set wins over a same-cycle clear.
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          flags_reg[g] <= 6'h00;
        else if (wr && bus_addr[`TPW_REG_MSB:0] == `TPW_G_CLR)
          flags_reg[g] <= (flags_reg[g] & ~bus_wdata[5:0]) | ev;
        else
          flags_reg[g] <= flags_reg[g] | ev;
      end

      assign irq_hit[g] = |(ev & sel_reg[g]);
      assign raw_sig[2*g]     = db_a_reg;
      assign raw_sig[2*g + 1] = db_b_reg;

      sequence s_zero_down;
        zero_ev && !ctl_reg[g][`TPW_CTL_UPDOWN] && per_eff != `TPW_CNT_ZERO;
      endsequence
      sequence s_next_tick;
        tick && !ctl_reg[g][`TPW_CTL_UPDOWN] && !sync_hit[g];
      endsequence

      a_zero_then_load: assert property (
        s_zero_down ##1 s_next_tick |-> load_ev)
        else $error("period pulse did not follow zero pulse");
      a_down_reload: assert property (
        (s_zero_down and !sync_hit[g]) |=>
          count_reg[g] == $past(per_eff))
        else $error("count-down did not reload period");
      a_dir_down_low: assert property (
        $past(!ctl_reg[g][`TPW_CTL_UPDOWN]) |-> !dir_reg)
        else $error("direction high in count-down mode");
      a_match_limit: assert property (
        (ma_act_reg <= per_act_reg || ev[3:2] == 2'h0) &&
        (mb_act_reg <= per_act_reg || ev[5:4] == 2'h0))
        else $error("match fired above period");
      a_match_masked: assert property (
        (zero_ev || load_ev) |-> ev[5:2] == 4'h0)
        else $error("match event not masked by zero or period");
      a_event_irq: assert property (
        |(ev & sel_reg[g]) |=> gen_irq[g])
        else $error("selected event did not raise interrupt");
      a_dead_gap: assert property (
        db_en_reg[g] && $past(db_en_reg[g]) |-> !(db_a_reg && db_b_reg))
        else $error("dead-band outputs high together");
      a_rise_hold: assert property (
        db_en_reg[g] && rise_reg[g] != `TPW_CNT_ZERO && $rose(wave_a_reg)
          |=> !db_a_reg)
        else $error("rising edge not delayed");
      a_stall_stop: assert property (
        stall_s_reg && ctl_reg[g][`TPW_CTL_STALL] &&
          count_reg[g] == `TPW_CNT_ZERO |->
          (!tick && ev == 6'h00) ##1 count_reg[g] == `TPW_CNT_ZERO)
        else $error("generator ran past zero during stall");
      a_sync_clear: assert property (
        sync_hit[g] |=> count_reg[g] == `TPW_CNT_ZERO)
        else $error("sync reset did not clear counter");
    end
  endgenerate

  // Fault forcing is applied before inversion, so forced means inactive.
  assign pin_next = (raw_sig & pass_mask_reg &
                     ~(force_mask_reg & {6{fault_s_reg}})) ^
                    pol_mask_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwm_pin   <= 6'h00;
      gen_irq   <= 3'h0;
      fault_irq <= 1'b0;
    end
    else
    begin
      pwm_pin   <= pin_next;
      gen_irq   <= irq_hit;
      fault_irq <= fault_s_reg;
    end
  end

  a_fault_force: assert property (
    fault_s_reg |=>
      ((pwm_pin ^ $past(pol_mask_reg)) & $past(force_mask_reg)) == 6'h00)
    else $error("fault did not force outputs inactive");
  a_pass_mask: assert property (
    1'b1 |=> ((pwm_pin ^ $past(pol_mask_reg)) & ~$past(pass_mask_reg))
             == 6'h00)
    else $error("disabled output reached its pin");

  assign rd_gen = bus_addr[`TPW_GEN_MSB:`TPW_GEN_LSB] - 2'h1;

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (bus_re && bus_addr[`TPW_GEN_MSB:`TPW_GEN_LSB] == 2'h0)
    begin
      case (bus_addr)
        `TPW_OFS_PASS:   rdata_next = {26'h0, pass_mask_reg};
        `TPW_OFS_POL:    rdata_next = {26'h0, pol_mask_reg};
        `TPW_OFS_FORCE:  rdata_next = {26'h0, force_mask_reg};
        `TPW_OFS_STATUS: rdata_next = {31'h0, fault_s_reg};
        default:         rdata_next = 32'h0000_0000;
      endcase
    end
    else if (bus_re)
    begin
      case (bus_addr[`TPW_REG_MSB:0])
        `TPW_G_CTL:    rdata_next = {27'h0, ctl_reg[rd_gen]};
        `TPW_G_SEL:    rdata_next = {26'h0, sel_reg[rd_gen]};
        `TPW_G_FLAGS:  rdata_next = {26'h0, flags_reg[rd_gen]};
        `TPW_G_PERIOD: rdata_next = {16'h0, per_sh_reg[rd_gen]};
        `TPW_G_COUNT:  rdata_next = {16'h0, count_reg[rd_gen]};
        `TPW_G_MA:     rdata_next = {16'h0, ma_sh_reg[rd_gen]};
        `TPW_G_MB:     rdata_next = {16'h0, mb_sh_reg[rd_gen]};
        `TPW_G_ACTA:   rdata_next = {20'h0, acta_reg[rd_gen]};
        `TPW_G_ACTB:   rdata_next = {20'h0, actb_reg[rd_gen]};
        `TPW_G_DBCTL:  rdata_next = {31'h0, db_en_reg[rd_gen]};
        `TPW_G_RISE:   rdata_next = {16'h0, rise_reg[rd_gen]};
        `TPW_G_FALL:   rdata_next = {16'h0, fall_reg[rd_gen]};
        default:       rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Read data is held only for the cycle after the strobe.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bus_rdata <= 32'h0000_0000;
    else
      bus_rdata <= rdata_next;
  end

endmodule : tpw_top
`default_nettype wire

// [verif/tpw_gate_drv.sv]
// Gate-driver model that flags any bridge leg driven on both sides.
`timescale 1ns/1ps
`default_nettype none
module tpw_gate_drv
(
  input  wire logic       clk,   // Bench clock
  input  wire logic       rst,   // Clears the flags
  input  wire logic [5:0] gate,  // Gate commands, active high
  output var  logic [2:0] shoot  // Sticky both-on flag per leg
);
  // Cycle sampling is enough: a real driver would filter shorter overlaps.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      shoot <= 3'h0;
    else
      for (int i = 0; i < 3; i++)
        if (gate[2*i] && gate[2*i+1])
          shoot[i] <= 1'b1;
  end
endmodule : tpw_gate_drv
`default_nettype wire

// [verif/three_generator_pwm_module_bench.sv]
// Self-checking bench for the three-generator PWM module.
`timescale 1ns/1ps
`default_nettype none
module three_generator_pwm_module_bench
  import tpw_pkg::*;
;
  logic        clk, rst, bus_we, bus_re, fault_pin, debug_stall;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata, bus_rdata;
  logic [5:0]  pwm_pin;
  logic [2:0]  gen_irq, shoot;
  logic        fault_irq;
  int          miscompares, n_compared;
  int          irq_bit;

  tpw_top dut (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
    .bus_rdata(bus_rdata), .fault_pin(fault_pin),
    .debug_stall(debug_stall), .pwm_pin(pwm_pin),
    .gen_irq(gen_irq), .fault_irq(fault_irq));
  tpw_gate_drv drv (.clk(clk), .rst(rst), .gate(pwm_pin),
    .shoot(shoot));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %0h", $time, m, got);
    end
  endtask : chk

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_we    <= 1'b1;
    @(posedge clk);
    bus_we    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_re   <= 1'b1;
    @(posedge clk);
    bus_re   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd

  // Skips a few cycles so a pulse already in flight is not measured.
  task automatic irq_gap(output int g);
    int k;
    k = 0;
    repeat (3) tick();
    do begin tick(); k++; end while (gen_irq[irq_bit] !== 1'b1 && k < 300);
    g = 0;
    do begin tick(); g++; end while (gen_irq[irq_bit] !== 1'b1 && g < 300);
  endtask : irq_gap

  task automatic irq_cnt(input int n, output int c);
    c = 0;
    repeat (n)
    begin
      tick();
      if (gen_irq[irq_bit] === 1'b1)
        c++;
    end
  endtask : irq_cnt

  task automatic hi(input int b, output int h);
    h = 0;
    repeat (20)
    begin
      tick();
      if (pwm_pin[b] === 1'b1)
        h++;
    end
  endtask : hi

  // First output goes high at zero and low at match A counting down.
  task automatic setup(input logic [31:0] ctl, per, ma, sel);
    wr(8'h40, 32'h0);
    wr(8'h50, per);
    wr(8'h58, ma);
    wr(8'h60, 32'h83);
    wr(8'h44, sel);
    wr(8'h04, 32'h1);
    wr(8'h40, ctl);
    repeat (30) tick();
  endtask : setup

  task automatic s_reset;
    logic [7:0]  al [6] = '{8'h08, 8'h0C, 8'h10, 8'h40, 8'h50, 8'hFC};
    logic [31:0] d;
    chk(pwm_pin, 32'h0, "pins after reset");
    wr(8'hFC, 32'hFFFFFFFF);
    foreach (al[i])
    begin
      rd(al[i], d);
      chk(d, 32'h0, "reset value");
    end
  endtask : s_reset

  task automatic s_down;
    int g, c;
    setup(32'h1, 32'h9, 32'h4, 32'h1);
    irq_gap(g);
    chk(g, 32'hA, "down period");
    wr(8'h44, 32'h08);
    irq_gap(g);
    chk(g, 32'hA, "match a down");
    wr(8'h58, 32'hA);
    repeat (12) tick();
    irq_cnt(40, c);
    chk(c, 32'h0, "match above period");
    wr(8'h44, 32'h1);
    wr(8'h50, 32'h4);
    repeat (12) tick();
    irq_gap(g);
    chk(g, 32'h5, "new period");
  endtask : s_down

  task automatic s_updown;
    int g, c;
    setup(32'h3, 32'h8, 32'h3, 32'h1);
    irq_gap(g);
    chk(g, 32'h10, "triangle period");
    wr(8'h44, 32'h05);
    repeat (4) tick();
    irq_cnt(32, c);
    chk(c, 32'h4, "zero and a up");
    wr(8'h44, 32'h08);
    irq_gap(g);
    chk(g, 32'h10, "a down only");
  endtask : s_updown

  task automatic s_wave;
    int h;
    setup(32'h1, 32'h9, 32'h4, 32'h0);
    wr(8'h08, 32'h0);
    hi(0, h);
    chk(h, 32'h0, "masked pin");
    wr(8'h08, 32'h3F);
    repeat (5) tick();
    hi(0, h);
    chk(h, 32'hC, "high time");
    wr(8'h0C, 32'h1);
    repeat (5) tick();
    hi(0, h);
    chk(h, 32'h8, "inverted");
    wr(8'h0C, 32'h0);
    // Coinciding matches: a leaked B on the first output holds it high,
    // a leaked A on the second cancels its toggle.
    wr(8'h5C, 32'h4);
    wr(8'h60, 32'hC83);
    wr(8'h64, 32'h442);
    repeat (12) tick();
    hi(0, h);
    chk(h, 32'hC, "first ignores match b");
    hi(1, h);
    chk(h, 32'h8, "second ignores match a");
    wr(8'h6C, 32'h3);
    wr(8'h70, 32'h2);
    wr(8'h68, 32'h1);
    repeat (20) tick();
    hi(0, h);
    chk(h, 32'h6, "rise gap");
    hi(1, h);
    chk(h, 32'h4, "fall gap");
    chk(shoot, 32'h0, "leg overlap");
    wr(8'h68, 32'h0);
  endtask : s_wave

  task automatic s_fault;
    logic [31:0] d;
    int          h;
    wr(8'h10, 32'h1);
    @(posedge clk);
    fault_pin <= 1'b1;
    repeat (5) tick();
    chk(fault_irq, 32'h1, "fault irq");
    rd(8'h20, d);
    chk(d, 32'h1, "fault status");
    hi(0, h);
    chk(h, 32'h0, "forced pin");
    @(posedge clk);
    fault_pin <= 1'b0;
    repeat (5) tick();
    hi(0, h);
    chk(h, 32'hC, "released pin");
  endtask : s_fault

  task automatic s_stall;
    logic [31:0] d;
    int          c;
    wr(8'h44, 32'h1);
    wr(8'h40, 32'h11);
    @(posedge clk);
    debug_stall <= 1'b1;
    repeat (30) tick();
    rd(8'h54, d);
    chk(d, 32'h0, "stopped at zero");
    irq_cnt(20, c);
    chk(c, 32'h0, "no stall events");
    @(posedge clk);
    debug_stall <= 1'b0;
    irq_gap(c);
    chk(c, 32'hA, "resumed");
  endtask : s_stall

  // Second generator: synced period stays pending, then both are synced.
  task automatic s_sync;
    logic [31:0] d;
    int          c;
    irq_bit = 1;
    wr(8'h90, 32'h9);
    wr(8'h84, 32'h1);
    wr(8'h80, 32'h5);
    repeat (3) tick();
    irq_cnt(10, c);
    chk(c, 32'hA, "period pending");
    wr(8'h00, 32'h2);
    irq_gap(c);
    chk(c, 32'hA, "period after update");
    wr(8'h04, 32'h3);
    rd(8'h54, d);
    chk(d, 32'h9, "first count after sync");
    rd(8'h94, d);
    chk(d, 32'h7, "second count after sync");
    irq_bit = 0;
  endtask : s_sync

  initial
  begin
    miscompares = 0;
    n_compared  = 0;
    irq_bit     = 0;
    rst         = 1'b1;
    bus_addr    = 8'h00;
    bus_wdata   = 32'h0;
    bus_we      = 1'b0;
    bus_re      = 1'b0;
    fault_pin   = 1'b0;
    debug_stall = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_down();
    s_updown();
    s_wave();
    s_fault();
    s_stall();
    s_sync();
    end_of_test();
  end

  // The scenarios take under a thousand cycles; the 50000-cycle limit leaves wide margin.
  initial
  begin
    #(40 * 50000);
    miscompares++;
    end_of_test();
  end
endmodule : three_generator_pwm_module_bench
`default_nettype wire
